/* src/rrxb_top.sv */
// Remote receiver frame buffer: bit buffer, assembler and Avalon-MM slave.
// Assumes the demodulator drives the bit stream on clk_in.
//
// The address map and the Avalon-MM register port were left to the implementer.
`timescale 1ns/1ns
module rrxb_top (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    input wire logic bit_valid_in,
    input wire logic bit_value_in,
    input wire logic bit_last_in,
    output logic bit_ready_out,
    input wire logic [4:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out
);
    rrxb_bit_if bit_link ();

    logic frame_valid;
    logic [71:0] frame_data;
    logic [6:0] frame_count;
    logic frame_over;

    // Buffer words and status
    logic [31:0] low_word_r, low_word_nxt;
    logic [31:0] mid_word_r, mid_word_nxt;
    logic [7:0] up_byte_r, up_byte_nxt;
    logic [6:0] last_cnt_r, last_cnt_nxt;
    logic new_r, new_nxt;
    logic ovr_r, ovr_nxt;
    logic cap_en_r, cap_en_nxt;

    // Bus slave state
    logic ack_r, ack_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic req;
    logic wr_fire;
    logic load;
    logic clr_new, clr_ovr;

    // Bit buffer in the data path
    rrxb_fifo u_fifo (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .ce_in(ce_in),
        .in_valid_in(bit_valid_in),
        .in_data_in({bit_last_in, bit_value_in}),
        .in_ready_out(bit_ready_out),
        .out(bit_link.src)
    );

    // Frame assembly
    rrxb_asm u_asm (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .ce_in(ce_in),
        .bits(bit_link.snk),
        .frame_valid_out(frame_valid),
        .frame_data_out(frame_data),
        .frame_count_out(frame_count),
        .frame_over_out(frame_over)
    );

    // Bus handshake: one wait cycle, answer on the second
    assign req = avs_read_in | avs_write_in;
    assign avs_waitrequest_out = ~ack_r;
    assign avs_readdata_out = rdata_r;
    assign wr_fire = avs_write_in & ack_r & ce_in;
    assign load = frame_valid & cap_en_r & ce_in;

    // Write-one-to-clear strobes for the status flags
    assign clr_new = wr_fire & (avs_address_in == rrxb_pkg::OFS_STAT)
        & avs_byteenable_in[1] & avs_writedata_in[rrxb_pkg::STAT_NEW_BIT];
    assign clr_ovr = wr_fire & (avs_address_in == rrxb_pkg::OFS_STAT)
        & avs_byteenable_in[1] & avs_writedata_in[rrxb_pkg::STAT_OVR_BIT];

    // Buffer words: loaded only at frame completion
    always_comb begin
        low_word_nxt = low_word_r;
        mid_word_nxt = mid_word_r;
        up_byte_nxt = up_byte_r;
        last_cnt_nxt = last_cnt_r;
        if (load) begin
            low_word_nxt = frame_data[rrxb_pkg::LOW_LSB +: 32];
            mid_word_nxt = frame_data[rrxb_pkg::MID_LSB +: 32];
            up_byte_nxt = frame_data[rrxb_pkg::UP_LSB +: rrxb_pkg::UP_BITS];
            last_cnt_nxt = frame_count;
        end
    end

    // Buffer word registers, zero after reset
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            low_word_r <= rrxb_pkg::RST_LOW;
            mid_word_r <= rrxb_pkg::RST_MID;
            up_byte_r <= rrxb_pkg::RST_UP;
            last_cnt_r <= rrxb_pkg::CNT_RST;
        end else if (ce_in) begin
            low_word_r <= low_word_nxt;
            mid_word_r <= mid_word_nxt;
            up_byte_r <= up_byte_nxt;
            last_cnt_r <= last_cnt_nxt;
        end
    end

    // Status flags and capture enable
    always_comb begin
        new_nxt = rrxb_pkg::rrxb_sticky(new_r, load, clr_new);
        ovr_nxt = rrxb_pkg::rrxb_sticky(ovr_r, load & frame_over, clr_ovr);
        cap_en_nxt = cap_en_r;
        if (wr_fire && avs_address_in == rrxb_pkg::OFS_CTRL && avs_byteenable_in[0]) begin
            cap_en_nxt = avs_writedata_in[rrxb_pkg::CTRL_EN_BIT];
        end
    end

    // Status and control registers
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            new_r <= 1'b0;
            ovr_r <= 1'b0;
            cap_en_r <= rrxb_pkg::RST_CAP_EN;
        end else if (ce_in) begin
            new_r <= new_nxt;
            ovr_r <= ovr_nxt;
            cap_en_r <= cap_en_nxt;
        end
    end

    // Read mux, sampled in the wait cycle
    always_comb begin
        ack_nxt = req & ~ack_r;
        rdata_nxt = rdata_r;
        if (req && !ack_r) begin
            case (avs_address_in)
                rrxb_pkg::OFS_LOW: rdata_nxt = low_word_r;
                rrxb_pkg::OFS_MID: rdata_nxt = mid_word_r;
                rrxb_pkg::OFS_UP: rdata_nxt = {24'h00_0000, up_byte_r};
                rrxb_pkg::OFS_STAT: begin
                    rdata_nxt = 32'h0000_0000;
                    rdata_nxt[rrxb_pkg::STAT_CNT_LSB +: rrxb_pkg::CNT_BITS] = last_cnt_r;
                    rdata_nxt[rrxb_pkg::STAT_NEW_BIT] = new_r;
                    rdata_nxt[rrxb_pkg::STAT_OVR_BIT] = ovr_r;
                end
                rrxb_pkg::OFS_CTRL: begin
                    rdata_nxt = 32'h0000_0000;
                    rdata_nxt[rrxb_pkg::CTRL_EN_BIT] = cap_en_r;
                end
                default: rdata_nxt = 32'h0000_0000;
            endcase
        end
    end

    // Bus slave registers
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            ack_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
        end else if (ce_in) begin
            ack_r <= ack_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // Low word takes frame bits 31:0 on a load
    property p_low_load;
        @(posedge clk_in) disable iff (rst_in)
        load |=> (low_word_r == $past(frame_data[31:0]));
    endproperty
    a_low_load: assert property (p_low_load) else $error("low word missed frame bits 31:0");

    // Middle word takes frame bits 63:32 on a load
    property p_mid_load;
        @(posedge clk_in) disable iff (rst_in)
        load |=> (mid_word_r == $past(frame_data[63:32]));
    endproperty
    a_mid_load: assert property (p_mid_load) else $error("middle word missed frame bits 63:32");

    // Upper byte takes frame bits 71:64 and reads with zero padding
    property p_up_read;
        @(posedge clk_in) disable iff (rst_in)
        (avs_read_in && !avs_waitrequest_out && avs_address_in == rrxb_pkg::OFS_UP)
            |-> (avs_readdata_out == {24'h00_0000, $past(up_byte_r)});
    endproperty
    a_up_read: assert property (p_up_read) else $error("upper byte read mismatch");

    // Whole image lands as one continuous run across the words
    property p_continuous;
        @(posedge clk_in) disable iff (rst_in)
        load |=> ({up_byte_r, mid_word_r, low_word_r} == $past(frame_data));
    endproperty
    a_continuous: assert property (p_continuous) else $error("frame image not continuous");

    // Buffer words hold whenever no frame completes
    property p_hold;
        @(posedge clk_in) disable iff (rst_in)
        !load |=> $stable({up_byte_r, mid_word_r, low_word_r});
    endproperty
    a_hold: assert property (p_hold) else $error("buffer changed between frames");

    // Final bit of a frame is readable at low word bit 0
    property p_last_low;
        @(posedge clk_in) disable iff (rst_in)
        load |=> (low_word_r[0] == $past(frame_data[0]));
    endproperty
    a_last_low: assert property (p_last_low) else $error("last bit not at low word bit 0");

    // A request is answered on the second cycle, never later
    property p_answer;
        @(posedge clk_in) disable iff (rst_in || !ce_in)
        (req && avs_waitrequest_out) |=> !avs_waitrequest_out;
    endproperty
    a_answer: assert property (p_answer) else $error("bus answer late");

    // A frame dropped while capture is off leaves the low word alone
    property p_gate;
        @(posedge clk_in) disable iff (rst_in)
        (frame_valid && !cap_en_r) |=> $stable(low_word_r);
    endproperty
    a_gate: assert property (p_gate) else $error("disabled capture changed buffer");

    // Waitrequest is high again after a cycle without a request
    property p_wait_idle;
        @(posedge clk_in) disable iff (rst_in || !ce_in)
        !req |=> avs_waitrequest_out;
    endproperty
    a_wait_idle: assert property (p_wait_idle) else $error("waitrequest low without a request");

    // Waitrequest stays low for exactly one cycle
    property p_wait_pulse;
        @(posedge clk_in) disable iff (rst_in || !ce_in)
        !avs_waitrequest_out |=> avs_waitrequest_out;
    endproperty
    a_wait_pulse: assert property (p_wait_pulse) else $error("waitrequest low for more than one cycle");

    // Read data holds until the next request is taken
    property p_rdata_hold;
        @(posedge clk_in) disable iff (rst_in || !ce_in)
        !(req && avs_waitrequest_out) |=> $stable(avs_readdata_out);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data changed without a request");

    // A loaded frame raises the new-frame flag, even against a clear
    property p_new_set;
        @(posedge clk_in) disable iff (rst_in)
        load |=> new_r;
    endproperty
    a_new_set: assert property (p_new_set) else $error("new frame flag not set");

    // A loaded overlong frame raises the overrun flag
    property p_ovr_set;
        @(posedge clk_in) disable iff (rst_in)
        (load && frame_over) |=> ovr_r;
    endproperty
    a_ovr_set: assert property (p_ovr_set) else $error("overrun flag not set");

    // Writing one clears the new-frame flag when no frame lands
    property p_new_clr;
        @(posedge clk_in) disable iff (rst_in)
        (clr_new && !load) |=> !new_r;
    endproperty
    a_new_clr: assert property (p_new_clr) else $error("new frame flag not cleared");

    // Writing one clears the overrun flag when no overrun lands
    property p_ovr_clr;
        @(posedge clk_in) disable iff (rst_in)
        (clr_ovr && !(load && frame_over)) |=> !ovr_r;
    endproperty
    a_ovr_clr: assert property (p_ovr_clr) else $error("overrun flag not cleared");

    // The bit count of a loaded frame is kept for status reads
    property p_cnt_load;
        @(posedge clk_in) disable iff (rst_in)
        load |=> (last_cnt_r == $past(frame_count));
    endproperty
    a_cnt_load: assert property (p_cnt_load) else $error("frame bit count not kept");

    // Capture enable follows a completed control write
    property p_cap_write;
        @(posedge clk_in) disable iff (rst_in)
        (wr_fire && avs_address_in == rrxb_pkg::OFS_CTRL && avs_byteenable_in[0])
            |=> (cap_en_r == $past(avs_writedata_in[rrxb_pkg::CTRL_EN_BIT]));
    endproperty
    a_cap_write: assert property (p_cap_write) else $error("capture enable write lost");

    // Low word reads back what it held when the read was taken
    property p_low_read;
        @(posedge clk_in) disable iff (rst_in || !ce_in)
        (avs_read_in && !avs_waitrequest_out && avs_address_in == rrxb_pkg::OFS_LOW)
            |-> (avs_readdata_out == $past(low_word_r));
    endproperty
    a_low_read: assert property (p_low_read) else $error("low word read mismatch");

    // All three buffer words are zero as reset ends
    property p_rst_zero;
        @(posedge clk_in) disable iff (rst_in)
        $fell(rst_in) |-> ({up_byte_r, mid_word_r, low_word_r} == {rrxb_pkg::RST_UP, rrxb_pkg::RST_MID, rrxb_pkg::RST_LOW});
    endproperty
    a_rst_zero: assert property (p_rst_zero) else $error("buffer words not zero after reset");

    // Addresses past the map read as zero
    property p_unmapped;
        @(posedge clk_in) disable iff (rst_in || !ce_in)
        (avs_read_in && !avs_waitrequest_out && avs_address_in > rrxb_pkg::OFS_CTRL)
            |-> (avs_readdata_out == 32'h0000_0000);
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped address read not zero");
endmodule

/* src/rrxb_pkg.sv */
// Constants, types and helpers for the remote receiver frame buffer.
// Assumes one clock; every other file names items as rrxb_pkg::name.
package rrxb_pkg;
    // Frame layout
    localparam int FRAME_BITS = 72;
    localparam int LOW_LSB = 0;
    localparam int MID_LSB = 32;
    localparam int UP_LSB = 64;
    localparam int UP_BITS = 8;
    localparam int CNT_BITS = 7;
    localparam logic [6:0] CNT_FULL = 7'h48;
    localparam logic [6:0] CNT_RST = 7'h00;

    // Register byte offsets
    localparam logic [4:0] OFS_LOW = 5'h00;
    localparam logic [4:0] OFS_MID = 5'h04;
    localparam logic [4:0] OFS_UP = 5'h08;
    localparam logic [4:0] OFS_STAT = 5'h0c;
    localparam logic [4:0] OFS_CTRL = 5'h10;

    // Reset values
    localparam logic [31:0] RST_LOW = 32'h0000_0000;
    localparam logic [31:0] RST_MID = 32'h0000_0000;
    localparam logic [7:0] RST_UP = 8'h00;
    localparam logic [71:0] RST_FRAME = 72'h0;
    localparam logic RST_CAP_EN = 1'b1;

    // Field positions
    localparam int STAT_CNT_LSB = 0;
    localparam int STAT_NEW_BIT = 8;
    localparam int STAT_OVR_BIT = 9;
    localparam int CTRL_EN_BIT = 0;

    // Bit buffer shape: one data bit plus the frame-end marker
    localparam int BUF_WIDTH = 2;
    localparam int BUF_DEPTH = 2;

    typedef enum logic {RRXB_COLLECT, RRXB_COMMIT} rrxb_asm_e;

    // Sticky flag update where a new event beats a clear
    function automatic logic rrxb_sticky(input logic cur, input logic set, input logic clr);
        rrxb_sticky = set | (cur & ~clr);
    endfunction
endpackage

/* src/rrxb_bit_if.sv */
// Bit stream carrier between the bit buffer and the frame assembler.
// Assumes both ends run on the same clock.
`timescale 1ns/1ns
interface rrxb_bit_if;
    logic valid;
    logic ready;
    logic bit_val;
    logic last;
    modport src (output valid, output bit_val, output last, input ready);
    modport snk (input valid, input bit_val, input last, output ready);
endinterface

/* src/rrxb_fifo.sv */
// Two-entry bit buffer with valid and ready on both sides.
// Assumes the writer honours in_ready_out and the reader may stall.
`timescale 1ns/1ns
module rrxb_fifo #(
    parameter int WIDTH = rrxb_pkg::BUF_WIDTH,
    parameter int DEPTH = rrxb_pkg::BUF_DEPTH
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    input wire logic in_valid_in,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic in_ready_out,
    rrxb_bit_if.src out
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [PW:0] FULL = (PW+1)'(DEPTH);
    localparam logic [PW-1:0] LASTP = PW'(DEPTH - 1);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [PW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
    logic [PW:0] cnt_r, cnt_nxt;
    logic push, pop;

    // Handshakes and honest full or empty
    assign in_ready_out = (cnt_r != FULL);
    assign out.valid = (cnt_r != '0);
    assign {out.last, out.bit_val} = mem_r[rp_r];
    assign push = in_valid_in & in_ready_out & ce_in;
    assign pop = out.valid & out.ready & ce_in;

    // Pointer and occupancy next values
    always_comb begin
        wp_nxt = wp_r;
        rp_nxt = rp_r;
        cnt_nxt = cnt_r;
        if (push) begin
            wp_nxt = (wp_r == LASTP) ? '0 : wp_r + 1'b1;
        end
        if (pop) begin
            rp_nxt = (rp_r == LASTP) ? '0 : rp_r + 1'b1;
        end
        if (push && !pop) begin
            cnt_nxt = cnt_r + 1'b1;
        end else if (pop && !push) begin
            cnt_nxt = cnt_r - 1'b1;
        end
    end

    // Pointer registers
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end else begin
            wp_r <= wp_nxt;
            rp_r <= rp_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // Storage, written only on a push
    always_ff @(posedge clk_in) begin
        if (push) begin
            mem_r[wp_r] <= in_data_in;
        end
    end
endmodule

/* src/rrxb_asm.sv */
// Frame assembler: shifts received bits into a 72-bit frame image.
// Assumes a bit stream whose last bit carries the frame-end marker.
`timescale 1ns/1ns
module rrxb_asm (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    rrxb_bit_if.snk bits,
    output logic frame_valid_out,
    output logic [71:0] frame_data_out,
    output logic [6:0] frame_count_out,
    output logic frame_over_out
);
    rrxb_pkg::rrxb_asm_e state_r, state_nxt;
    logic [71:0] shift_r, shift_nxt;
    logic [6:0] cnt_r, cnt_nxt;
    logic over_r, over_nxt;
    logic take;

    // Stall the buffer during the commit cycle
    assign bits.ready = (state_r == rrxb_pkg::RRXB_COLLECT);
    assign take = bits.valid & bits.ready;
    assign frame_valid_out = (state_r == rrxb_pkg::RRXB_COMMIT);
    assign frame_data_out = shift_r;
    assign frame_count_out = cnt_r;
    assign frame_over_out = over_r;

    // Shift and count next values
    always_comb begin
        state_nxt = state_r;
        shift_nxt = shift_r;
        cnt_nxt = cnt_r;
        over_nxt = over_r;
        case (state_r)
            rrxb_pkg::RRXB_COLLECT: begin
                if (take) begin
                    shift_nxt = {shift_r[70:0], bits.bit_val};
                    if (cnt_r == rrxb_pkg::CNT_FULL) begin
                        over_nxt = 1'b1;
                    end else begin
                        cnt_nxt = cnt_r + 1'b1;
                    end
                    if (bits.last) begin
                        state_nxt = rrxb_pkg::RRXB_COMMIT;
                    end
                end
            end
            rrxb_pkg::RRXB_COMMIT: begin
                shift_nxt = rrxb_pkg::RST_FRAME;
                cnt_nxt = rrxb_pkg::CNT_RST;
                over_nxt = 1'b0;
                state_nxt = rrxb_pkg::RRXB_COLLECT;
            end
            default: begin
                state_nxt = rrxb_pkg::RRXB_COLLECT;
            end
        endcase
    end

    // Assembler registers, frozen while ce_in is low
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_r <= rrxb_pkg::RRXB_COLLECT;
            shift_r <= rrxb_pkg::RST_FRAME;
            cnt_r <= rrxb_pkg::CNT_RST;
            over_r <= 1'b0;
        end else if (ce_in) begin
            state_r <= state_nxt;
            shift_r <= shift_nxt;
            cnt_r <= cnt_nxt;
            over_r <= over_nxt;
        end
    end

    // Earlier bits move one place up on every non-final bit
    property p_older_up;
        @(posedge clk_in) disable iff (rst_in || !ce_in)
        (take && !bits.last) |=> (shift_r[71:1] == $past(shift_r[70:0]));
    endproperty
    a_older_up: assert property (p_older_up) else $error("older bits did not move up");

    // Final bit of a frame lands at bit 0 of the image
    property p_last_at_zero;
        @(posedge clk_in) disable iff (rst_in || !ce_in)
        (take && bits.last) |=> (frame_valid_out && frame_data_out[0] == $past(bits.bit_val));
    endproperty
    a_last_at_zero: assert property (p_last_at_zero) else $error("last bit not at position 0");
endmodule

/* tb/rrxb_tx_model.sv */
// Remote transmitter model driving the received-bit stream of the frame buffer.
// Assumes the stream is taken on the rising edge of clk_in while ready is high.
`timescale 1ns/1ns
module rrxb_tx_model (
    input wire logic clk_in,
    input wire logic ready_in,
    output logic valid_out,
    output logic value_out,
    output logic last_out
);
    // Idle stream at time zero
    initial begin
        valid_out = 1'b0;
        value_out = 1'b0;
        last_out = 1'b0;
    end

    // Sends the low n bits, highest first, each held until taken; keep leaves valid up
    task automatic send_frame(input logic [71:0] data, input int n, input logic end_frame, input logic keep);
        for (int i = n - 1; i >= 0; i--) begin
            valid_out <= 1'b1;
            value_out <= data[i];
            last_out <= end_frame && (i == 0);
            do begin
                @(posedge clk_in);
            end while (ready_in !== 1'b1);
        end
        // Released line shows the inverse of the last bit, never a stale copy
        if (!keep) begin
            valid_out <= 1'b0;
            value_out <= ~value_out;
            last_out <= 1'b0;
        end
    endtask
endmodule

/* tb/rrxb_top_test.sv */
// Self-checking bench for the remote receiver frame buffer.
// Assumes an Avalon-MM master here and the transmitter model on the bit stream.
`timescale 1ns/1ns
module rrxb_top_test;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic ce_in = 1'b1;
    logic bit_valid;
    logic bit_value;
    logic bit_last;
    logic bit_ready;
    logic [4:0] avs_address = 5'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    int n_fail = 0;
    int n_tests = 0;

    rrxb_top uut (.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in), .bit_valid_in(bit_valid),
        .bit_value_in(bit_value), .bit_last_in(bit_last), .bit_ready_out(bit_ready),
        .avs_address_in(avs_address), .avs_read_in(avs_read), .avs_write_in(avs_write),
        .avs_writedata_in(avs_writedata), .avs_byteenable_in(4'hf), .avs_readdata_out(avs_readdata),
        .avs_waitrequest_out(avs_waitrequest));

    rrxb_tx_model tx (.clk_in(clk_in), .ready_in(bit_ready), .valid_out(bit_valid), .value_out(bit_value),
        .last_out(bit_last));

    // 20 MHz clock
    always #25 clk_in = ~clk_in;

    // Verdict and end of run
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    // One Avalon-MM transfer, held until waitrequest is seen low at a rising edge
    task automatic bus(input logic wr, input logic [4:0] addr, input logic [31:0] wdata, output logic [31:0] rdata);
        int k = 0;
        @(posedge clk_in);
        avs_address <= addr;
        avs_writedata <= wdata;
        avs_read <= ~wr;
        avs_write <= wr;
        do begin
            @(posedge clk_in);
            k++;
        end while (avs_waitrequest !== 1'b0 && k < 50);
        if (avs_waitrequest !== 1'b0) begin
            n_fail++;
            $display("[FAIL] t=%0t bus wait got %h exp %h", $time, avs_waitrequest, 1'b0);
        end
        rdata = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic rd(input logic [4:0] addr, input logic [31:0] exp);
        logic [31:0] d;
        bus(1'b0, addr, 32'h0, d);
        chk(d, exp);
    endtask

    task automatic wr(input logic [4:0] addr, input logic [31:0] data);
        logic [31:0] d;
        bus(1'b1, addr, data, d);
    endtask

    // Polls status until the bit count matches, then clears the sticky flags
    task automatic wait_frame(input logic [6:0] cnt);
        logic [31:0] d;
        int k = 0;
        bus(1'b0, rrxb_pkg::OFS_STAT, 32'h0, d);
        while (!(d[8] === 1'b1 && d[6:0] === cnt) && k < 40) begin
            bus(1'b0, rrxb_pkg::OFS_STAT, 32'h0, d);
            k++;
        end
        chk({25'h0, d[6:0]}, {25'h0, cnt});
        wr(rrxb_pkg::OFS_STAT, 32'h0000_0300);
    endtask

    task automatic words(input logic [71:0] exp);
        rd(rrxb_pkg::OFS_LOW, exp[31:0]);
        rd(rrxb_pkg::OFS_MID, exp[63:32]);
        rd(rrxb_pkg::OFS_UP, {24'h0, exp[71:64]});
    endtask

    task automatic t_reset();
        words({rrxb_pkg::RST_UP, rrxb_pkg::RST_MID, rrxb_pkg::RST_LOW});
        rd(5'h14, 32'h0);
        rd(rrxb_pkg::OFS_CTRL, {31'h0, rrxb_pkg::RST_CAP_EN});
        $display("test reset done");
    endtask

    // Full 72-bit frame: first bit lands at 71, last bit at 0
    task automatic t_full();
        logic [71:0] d = 72'hc3_9a5f_0e17_6b2d_4489;
        tx.send_frame(d, 72, 1'b1, 1'b0);
        wait_frame(rrxb_pkg::CNT_FULL);
        words(d);
        $display("test full frame done");
    endtask

    // Byte payload sent least significant bit first; software reverses it
    task automatic t_lsb();
        logic [7:0] pay = 8'h1d;
        logic [31:0] d;
        tx.send_frame({64'h0, pay[0], pay[1], pay[2], pay[3], pay[4], pay[5], pay[6], pay[7]}, 8, 1'b1, 1'b0);
        wait_frame(7'h08);
        words(72'hb8);
        bus(1'b0, rrxb_pkg::OFS_LOW, 32'h0, d);
        chk({24'h0, d[0], d[1], d[2], d[3], d[4], d[5], d[6], d[7]}, {24'h0, pay});
        $display("test lsb first done");
    endtask

    // Writes to the buffer words leave them unchanged
    task automatic t_readonly();
        wr(rrxb_pkg::OFS_LOW, 32'hffff_ffff);
        wr(rrxb_pkg::OFS_MID, 32'hffff_ffff);
        wr(rrxb_pkg::OFS_UP, 32'hffff_ffff);
        words(72'hb8);
        $display("test read only done");
    endtask

    // Words hold over a partial frame and while capture is off
    task automatic t_hold();
        tx.send_frame(72'ha_b3c5, 20, 1'b0, 1'b0);
        repeat (10) @(posedge clk_in);
        words(72'hb8);
        tx.send_frame(72'h6, 4, 1'b1, 1'b0);
        wait_frame(7'h18);
        words(72'hab_3c56);
        wr(rrxb_pkg::OFS_CTRL, 32'h0);
        tx.send_frame(72'h1234, 16, 1'b1, 1'b0);
        repeat (20) @(posedge clk_in);
        words(72'hab_3c56);
        wr(rrxb_pkg::OFS_CTRL, 32'h1);
        $display("test hold done");
    endtask

    // Two frames with no gap lose no bit; a 73-bit frame keeps its last 72 and flags overrun
    task automatic t_b2b();
        logic [71:0] b = 72'h5e_81f2_37c4_a906_1bd7;
        tx.send_frame(72'h2c5, 10, 1'b1, 1'b1);
        tx.send_frame(72'h1, 1, 1'b0, 1'b1);
        tx.send_frame(b, 72, 1'b1, 1'b0);
        repeat (6) @(posedge clk_in);
        rd(rrxb_pkg::OFS_STAT, 32'h0000_0348);
        wait_frame(rrxb_pkg::CNT_FULL);
        words(b);
        $display("test back to back done");
    endtask
    // Watchdog
    initial begin
        #(20000 * 50);
        n_fail++;
        $display("[FAIL] t=%0t watchdog got %h exp %h", $time, 1'b1, 1'b0);
        end_of_test();
    end

    // Main sequence
    initial begin
        repeat (8) @(posedge clk_in);
        rst_in <= 1'b0;
        t_reset();
        t_full();
        t_lsb();
        t_readonly();
        t_hold();
        t_b2b();
        end_of_test();
    end
endmodule
